//--- cild_pkg.sv
// Package for the compact load and move decode block.
// Holds opcodes, function codes, exception codes, state type and carriers.
package cild_pkg;

	// Major opcodes of the short instruction word.
	localparam logic [4:0] OP_EXTEND = 5'h1E;
	localparam logic [4:0] OP_LOAD_WORD = 5'h13;
	localparam logic [4:0] OP_PC_WORD = 5'h16;
	localparam logic [4:0] OP_SP_WORD = 5'h12;
	localparam logic [4:0] OP_REG_PAIR = 5'h1D;
	localparam logic [4:0] OP_IMM8 = 5'h0C;
	// Function and subfunction codes.
	localparam logic [4:0] FN_COPY_HIGH = 5'h10;
	localparam logic [4:0] FN_COPY_LOW = 5'h12;
	localparam logic [2:0] SUB_MOVE_FULL = 3'h5;
	localparam logic [2:0] ZERO3 = 3'h0;
	// Stack pointer register index.
	localparam logic [4:0] SP_INDEX = 5'h1D;
	// Exception codes reported on the exception port.
	localparam logic [2:0] EXC_NONE = 3'h0;
	localparam logic [2:0] EXC_ADDR = 3'h1;
	localparam logic [2:0] EXC_REFILL = 3'h2;
	localparam logic [2:0] EXC_INVALID = 3'h3;
	localparam logic [2:0] EXC_BUS = 3'h4;
	// Reset values.
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [4:0] IDX_RESET = 5'h00;

	// Sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_MEM
	} cild_state_e;

	// Instruction offered by fetch.
	typedef struct packed {
		logic valid;
		logic [15:0] word;
		logic [15:0] prefix;
		logic has_prefix;
		logic in_delay_slot;
		logic [31:0] pc;
		logic [31:0] jump_pc;
	} cild_inst_s;

	// Data memory request.
	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic is_data;
	} cild_mreq_s;

	// Data memory response.
	typedef struct packed {
		logic valid;
		logic [31:0] data;
		logic refill;
		logic invalid;
		logic bus_err;
	} cild_mrsp_s;

	// Register file write.
	typedef struct packed {
		logic en;
		logic [4:0] idx;
		logic [31:0] data;
	} cild_wb_s;

	// All state of the block.
	typedef struct packed {
		cild_state_e state;
		logic busy;
		cild_mreq_s mreq;
		cild_wb_s wb;
		logic [4:0] dest;
		logic exc_valid;
		logic [2:0] exc_code;
		logic done;
	} cild_state_s;

endpackage : cild_pkg

//--- cild_decode.sv
// Decode and execute of word loads, product register copies and full moves.
// Assumes fetch holds an instruction until busy drops and memory answers once.
//
// Functional notes
// [RULE1] Short load: offset times four plus base.
// [RULE2] Misaligned word load raises address error.
// [RULE3] Extended load: assembled sixteen-bit signed offset.
// [RULE4] Short PC load: offset times four plus PC.
// [RULE5] Short PC load clears two low address bits.
// [RULE6] Short PC load never raises address error.
// [RULE7] Extended PC load: aligned PC plus offset.
// [RULE8] Supplier keeps extended PC load off slots.
// [RULE9] PC-relative accesses are marked data references.
// [RULE10] Short stack load: offset times four plus r29.
// [RULE11] Extended stack load: signed offset plus r29.
// [RULE12] Loaded word written back unchanged.
// [RULE13] Copy high product into mapped register.
// [RULE14] Copy low product into mapped register.
// [RULE15] Move mapped register into any full register.
// [RULE16] Word 0x6500 executes as ordinary move.
// [RULE17] Three-bit fields map to architectural indices.
// [RULE18] Faulting load leaves destination unchanged.
`timescale 1ns/1ps
module cild_decode (
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Instruction from fetch.
	input wire cild_pkg::cild_inst_s inst,
	output logic busy,
	// Register file read ports, combinational answer.
	output logic [4:0] rd_a_idx,
	output logic [4:0] rd_b_idx,
	input wire logic [31:0] rd_a_data,
	input wire logic [31:0] rd_b_data,
	// Product registers.
	input wire logic [31:0] high_product_register,
	input wire logic [31:0] low_product_register,
	// Data memory and translation.
	output cild_pkg::cild_mreq_s mreq,
	input wire cild_pkg::cild_mrsp_s mrsp,
	// Register write and exception report.
	output cild_pkg::cild_wb_s wb,
	output logic exc_valid,
	output logic [2:0] exc_code,
	output logic done
);
	import cild_pkg::*;

	// Current and next state.
	cild_state_s state_reg;
	cild_state_s state_next;

	// Maps a three-bit compact field onto the register file.
	function automatic logic [4:0] map3(input logic [2:0] f);
		// [RULE17] compact register map
		map3 = (f[2:1] == 2'h0) ? {2'h2, f} : {2'h0, f};
	endfunction : map3

	// Instruction fields.
	logic [4:0] major;
	logic [2:0] first_compact_field;
	logic [2:0] second_compact_field_f;
	logic [15:0] ext_off;
	logic [31:0] ext_sx;
	logic [31:0] ea;
	logic check_align;
	logic [4:0] full_register_target_field;
	logic [2:0] source_compact_register_field;

	// Field slicing and extended offset assembly.
	always_comb begin
		major = inst.word[15:11];
		first_compact_field = inst.word[10:8];
		second_compact_field_f = inst.word[7:5];
		source_compact_register_field = inst.word[2:0];
		// [RULE15] target index split
		full_register_target_field = {inst.word[4:3], inst.word[7:5]};
		// [RULE3] extended offset assembly
		ext_off = {inst.prefix[4:0], inst.prefix[10:5], inst.word[4:0]};
		ext_sx = {{16{ext_off[15]}}, ext_off};
	end

	// Read port selection: port a is a base or source, port b is unused here.
	always_comb begin
		rd_a_idx = map3(first_compact_field);
		rd_b_idx = IDX_RESET;
		if (major == OP_SP_WORD) begin
			rd_a_idx = SP_INDEX;
		end else if (major == OP_IMM8) begin
			rd_a_idx = map3(source_compact_register_field);
		end
	end

	// Next-state logic: decode, address forming, response handling.
	always_comb begin
		state_next = state_reg;
		state_next.wb.en = 1'b0;
		state_next.exc_valid = 1'b0;
		state_next.done = 1'b0;
		state_next.mreq.valid = 1'b0;
		ea = WORD_RESET;
		check_align = 1'b1;
		case (state_reg.state)
			ST_IDLE: begin
				if (inst.valid) begin
					if (major == OP_LOAD_WORD) begin
						// [RULE1] scaled zero-extended offset
						ea = rd_a_data + (inst.has_prefix ? ext_sx : {25'h0, inst.word[4:0], 2'h0});
						state_next.dest = map3(second_compact_field_f);
					end else if (major == OP_PC_WORD && !inst.has_prefix) begin
						// [RULE4] slot-aware PC base
						ea = (inst.in_delay_slot ? inst.jump_pc : inst.pc) + {22'h0, inst.word[7:0], 2'h0};
						// [RULE5] force word alignment
						ea[1:0] = 2'h0;
						// [RULE6] no alignment check
						check_align = 1'b0;
						state_next.dest = map3(first_compact_field);
					end else if (major == OP_PC_WORD) begin
						// [RULE7] aligned PC base; [RULE8] slot case not handled
						ea = {inst.pc[31:2], 2'h0} + ext_sx;
						state_next.dest = map3(first_compact_field);
					end else if (major == OP_SP_WORD) begin
						// [RULE10] [RULE11] stack-relative base
						ea = rd_a_data + (inst.has_prefix ? ext_sx : {22'h0, inst.word[7:0], 2'h0});
						state_next.dest = map3(first_compact_field);
					end
					if (major == OP_LOAD_WORD || major == OP_PC_WORD || major == OP_SP_WORD) begin
						// [RULE2] alignment check
						if (check_align && ea[1:0] != 2'h0) begin
							state_next.exc_valid = 1'b1;
							state_next.exc_code = EXC_ADDR;
							state_next.done = 1'b1;
						end else begin
							state_next.mreq.valid = 1'b1;
							state_next.mreq.addr = ea;
							// [RULE9] data reference
							state_next.mreq.is_data = 1'b1;
							state_next.busy = 1'b1;
							state_next.state = ST_MEM;
						end
					end else if (major == OP_REG_PAIR && inst.word[4:0] == FN_COPY_HIGH
						&& second_compact_field_f == ZERO3) begin
						// [RULE13] copy high product
						state_next.wb = '{1'b1, map3(first_compact_field), high_product_register};
						state_next.done = 1'b1;
					end else if (major == OP_REG_PAIR && inst.word[4:0] == FN_COPY_LOW) begin
						// [RULE14] copy low product
						state_next.wb = '{1'b1, map3(first_compact_field), low_product_register};
						state_next.done = 1'b1;
					end else if (major == OP_IMM8 && first_compact_field == SUB_MOVE_FULL) begin
						// [RULE15] [RULE16] plain move, no-op included
						state_next.wb = '{1'b1, full_register_target_field, rd_a_data};
						state_next.done = 1'b1;
					end
				end
			end
			ST_MEM: begin
				// Request stays up until the answer, address held.
				state_next.mreq.valid = ~mrsp.valid;
				if (mrsp.valid) begin
					state_next.state = ST_IDLE;
					state_next.busy = 1'b0;
					state_next.done = 1'b1;
					if (mrsp.refill || mrsp.invalid || mrsp.bus_err) begin
						// [RULE18] fault suppresses write
						state_next.exc_valid = 1'b1;
						state_next.exc_code = mrsp.refill ? EXC_REFILL
							: (mrsp.invalid ? EXC_INVALID : EXC_BUS);
					end else begin
						// [RULE12] word written unchanged
						state_next.wb = '{1'b1, state_reg.dest, mrsp.data};
					end
				end
			end
			default: begin
				state_next.state = ST_IDLE;
			end
		endcase
	end

	// State register with synchronous reset.
	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= '{ST_IDLE, 1'b0, '{1'b0, WORD_RESET, 1'b0},
				'{1'b0, IDX_RESET, WORD_RESET}, IDX_RESET, 1'b0, EXC_NONE, 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs come straight from the state register.
	assign busy = state_reg.busy;
	assign mreq = state_reg.mreq;
	assign wb = state_reg.wb;
	assign exc_valid = state_reg.exc_valid;
	assign exc_code = state_reg.exc_code;
	assign done = state_reg.done;

endmodule : cild_decode

//--- cild_mem_model.sv
// Far-side model of data memory and translation for the decoder.
// Answers after lat cycles; flt picks a fault: 1 refill, 2 invalid, 3 bus.
`timescale 1ns/1ps
module cild_mem_model (
	// Clock, reset and bench controls.
	input wire logic clk,
	input wire logic srst,
	input wire logic [3:0] lat,
	input wire logic [1:0] flt,
	// Request in, response out.
	input wire cild_pkg::cild_mreq_s mreq,
	output cild_pkg::cild_mrsp_s mrsp
);
	import cild_pkg::*;
	logic [3:0] cnt_reg;
	logic sent_reg;
	// One answer per request; data toggles when idle so stale data never matches.
	// Each field is written once per edge so the answer never races the idle toggle.
	always_ff @(posedge clk) begin
		if (srst || !mreq.valid) begin
			cnt_reg <= 4'h0;
			sent_reg <= 1'b0;
			mrsp.valid <= 1'b0;
			mrsp.data <= ~mrsp.data;
		end else if (!sent_reg && cnt_reg == lat) begin
			mrsp <= '{1'b1, ~mreq.addr, flt == 2'h1, flt == 2'h2, flt == 2'h3};
			sent_reg <= 1'b1;
		end else begin
			mrsp.valid <= 1'b0;
			mrsp.data <= ~mrsp.data;
			cnt_reg <= cnt_reg + 4'h1;
		end
	end
endmodule : cild_mem_model

//--- cild_decode_chk.sv
// Assertions on the decoder ports.
// Bound to the decoder from the bench file.
`timescale 1ns/1ps
module cild_decode_chk (
	input wire logic clk,
	input wire logic srst,
	input wire cild_pkg::cild_inst_s inst,
	input wire logic busy,
	input wire logic [31:0] high_product_register,
	input wire logic [31:0] low_product_register,
	input wire cild_pkg::cild_mreq_s mreq,
	input wire cild_pkg::cild_mrsp_s mrsp,
	input wire cild_pkg::cild_wb_s wb,
	input wire logic exc_valid
);
	import cild_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// A short instruction accepted by the decoder.
	sequence s_take; inst.valid && !busy && !inst.has_prefix; endsequence
	// A memory answer to a pending load.
	sequence s_ans; mreq.valid && mrsp.valid; endsequence
	logic bad;
	assign bad = mrsp.refill | mrsp.invalid | mrsp.bus_err;
	property p_align; mreq.valid |-> mreq.addr[1:0] == 2'h0; endproperty
	a_align: assert property (p_align) else $error("misaligned access");
	property p_data; mreq.valid |-> mreq.is_data; endproperty
	a_data: assert property (p_data) else $error("not a data access");
	property p_hi; s_take ##0 inst.word[15:11] == OP_REG_PAIR && inst.word[7:0] == 8'h10
		|=> wb.en && !exc_valid && wb.data == $past(high_product_register); endproperty
	a_hi: assert property (p_hi) else $error("high copy wrong");
	property p_lo; s_take ##0 inst.word[15:11] == OP_REG_PAIR && inst.word[4:0] == FN_COPY_LOW
		|=> wb.en && !exc_valid && wb.data == $past(low_product_register); endproperty
	a_lo: assert property (p_lo) else $error("low copy wrong");
	property p_nop; s_take ##0 inst.word == 16'h6500 |=> wb.en && wb.idx == 5'h00; endproperty
	a_nop: assert property (p_nop) else $error("idle move wrong");
	property p_pcs; s_take ##0 inst.word[15:11] == OP_PC_WORD |=> mreq.valid && !exc_valid;
	endproperty
	a_pcs: assert property (p_pcs) else $error("pc load refused");
	property p_load; s_ans ##0 !bad |=> wb.en && wb.data == $past(mrsp.data); endproperty
	a_load: assert property (p_load) else $error("load data wrong");
	property p_fault; s_ans ##0 bad |=> exc_valid && !wb.en; endproperty
	a_fault: assert property (p_fault) else $error("fault wrote back");
endmodule : cild_decode_chk

//--- cild_decode_bench.sv
// Self-checking bench for the decoder with random and corner instructions.
// A memory model answers loads; register file is combinational here.
`timescale 1ns/1ps
module cild_decode_bench;
	import cild_pkg::*;
	logic clk, srst, busy, exc_valid, done;
	logic [4:0] rd_a_idx, rd_b_idx;
	logic [31:0] rd_a_data, rd_b_data, high_product_register, low_product_register, rbase, r;
	logic [3:0] lat;
	logic [1:0] flt;
	logic [2:0] exc_code;
	cild_inst_s inst, ii;
	cild_mreq_s mreq;
	cild_mrsp_s mrsp;
	cild_wb_s wb;
	int n_mismatch, n_tests, kd;
	logic [4:0] ops [9] = '{OP_LOAD_WORD, OP_LOAD_WORD, OP_PC_WORD, OP_PC_WORD,
		OP_SP_WORD, OP_SP_WORD, OP_REG_PAIR, OP_REG_PAIR, OP_IMM8};
	logic [15:0] cw [2] = '{16'h6500, {OP_IMM8, SUB_MOVE_FULL, 3'h7, 2'h3, 3'h1}};
	// Each register holds rbase with its index folded into the top bits.
	assign rd_a_data = rbase ^ {rd_a_idx, 27'h0};
	assign rd_b_data = rbase ^ {rd_b_idx, 27'h0};
	function automatic logic [31:0] rb(input logic [4:0] i);
		return rbase ^ {i, 27'h0};
	endfunction : rb
	function automatic logic [4:0] mp(input logic [2:0] f);
		return f < 3'h2 ? {4'h8, f[0]} : {2'h0, f};
	endfunction : mp
	function automatic logic [31:0] nx(input logic [31:0] x);
		repeat (9) x = x[0] ? (x >> 1) ^ 32'hA300_0000 : x >> 1;
		return x;
	endfunction : nx
	cild_decode dut (
		.clk(clk),
		.srst(srst),
		.inst(inst),
		.busy(busy),
		.rd_a_idx(rd_a_idx),
		.rd_b_idx(rd_b_idx),
		.rd_a_data(rd_a_data),
		.rd_b_data(rd_b_data),
		.high_product_register(high_product_register),
		.low_product_register(low_product_register),
		.mreq(mreq),
		.mrsp(mrsp),
		.wb(wb),
		.exc_valid(exc_valid),
		.exc_code(exc_code),
		.done(done)
	);
	cild_mem_model mem (
		.clk(clk),
		.srst(srst),
		.lat(lat),
		.flt(flt),
		.mreq(mreq),
		.mrsp(mrsp)
	);
	always #2 clk = ~clk;
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic summarize();
		if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	// Issue one instruction, wait for completion, check the outcome.
	task automatic run(input cild_inst_s t);
		logic [31:0] a, e, ma, s;
		logic [4:0] op, d;
		logic [2:0] c;
		logic ld;
		s = 32'(signed'({t.prefix[4:0], t.prefix[10:5], t.word[4:0]}));
		op = t.word[15:11];
		ld = op != OP_REG_PAIR && op != OP_IMM8;
		a = (op == OP_SP_WORD) ? rb(SP_INDEX) : rb(mp(t.word[10:8]));
		d = mp(t.word[10:8]);
		ma = 32'h0;
		a = a + (t.has_prefix ? s : 32'({t.word[7:0], 2'h0}));
		if (op == OP_LOAD_WORD) begin
			a = rb(mp(t.word[10:8])) + (t.has_prefix ? s : 32'({t.word[4:0], 2'h0}));
			d = mp(t.word[7:5]);
		end
		if (op == OP_PC_WORD) a = t.has_prefix ? {t.pc[31:2], 2'h0} + s :
			((t.in_delay_slot ? t.jump_pc : t.pc) + 32'({t.word[7:0], 2'h0})) & ~32'h3;
		e = ld ? ~a : t.word[1] ? low_product_register : high_product_register;
		if (op == OP_IMM8) e = rb(mp(t.word[2:0]));
		if (op == OP_IMM8) d = {t.word[4:3], t.word[7:5]};
		c = EXC_NONE;
		if (ld && a[1:0] != 2'h0 && (t.has_prefix || op != OP_PC_WORD)) c = EXC_ADDR;
		else if (ld && flt != 2'h0) c = 3'(flt) + 3'h1;
		inst = t;
		@(posedge clk);
		#1 inst.valid = 1'b0;
		// Only a load that passes the alignment check goes to memory.
		cmp("busy", ld && c != EXC_ADDR, busy);
		for (int k = 0; k < 40 && done !== 1'b1; k++) begin
			if (mreq.valid === 1'b1) ma = mreq.addr;
			@(posedge clk);
			#1;
		end
		cmp("done", 1, done);
		cmp("exc_valid", c != EXC_NONE, exc_valid);
		if (c != EXC_NONE) cmp("exc_code", c, exc_code);
		cmp("wb_en", c == EXC_NONE, wb.en);
		if (c == EXC_NONE) cmp("wb_idx", d, wb.idx);
		if (c == EXC_NONE) cmp("wb_data", e, wb.data);
		if (ld && c != EXC_ADDR) cmp("addr", a, ma);
		// Let one edge pass so the next request never rewrites valid in this time step.
		@(posedge clk);
		#1;
	endtask : run
	initial begin
		#100000;
		n_mismatch++;
		summarize();
	end
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		inst = '0;
		{lat, flt, rbase, high_product_register, low_product_register} = '0;
		r = 32'h0000_70D4;
		repeat (3) @(posedge clk);
		#1 srst = 1'b0;
		foreach (cw[i]) begin
			ii = '0;
			ii.valid = 1'b1;
			ii.word = cw[i];
			run(ii);
		end
		for (int t = 0; t < 400; t++) begin
			r = nx(r);
			ii.word = r[15:0];
			ii.prefix = {OP_EXTEND, r[26:16]};
			r = nx(r);
			kd = r[3:0] % 9;
			ii.word[15:11] = ops[kd];
			ii.has_prefix = kd < 6 && kd[0];
			if (kd == 3 || kd == 5 || kd == 6) ii.word[7:5] = ZERO3;
			if (kd == 6) ii.word[4:0] = FN_COPY_HIGH;
			if (kd == 7) ii.word[4:0] = FN_COPY_LOW;
			if (kd == 8) ii.word[10:8] = SUB_MOVE_FULL;
			// Extended PC load kept off slots.
			ii.in_delay_slot = r[4] && kd != 3;
			ii.valid = 1'b1;
			ii.pc = {r[31:1], 1'b0};
			lat = r[8:5];
			flt = r[10:9] == 2'h3 ? r[12:11] : 2'h0;
			r = nx(r);
			ii.jump_pc = {r[31:1], 1'b0};
			high_product_register = r;
			r = nx(r);
			low_product_register = r;
			r = nx(r);
			rbase = r[7] ? {r[31:2], 2'h0} : r;
			run(ii);
		end
		summarize();
	end
endmodule : cild_decode_bench
bind cild_decode cild_decode_chk u_chk (.*);
